//--- drs_pkg.sv
package drs_pkg;
  // multi-function input modes
  localparam logic [1:0] MFI_MODE_VOLTAGE = 2'h1;
  localparam logic [1:0] MFI_MODE_CURRENT = 2'h2;
  localparam logic [1:0] MFI_MODE_DIGITAL = 2'h3;
  // actual speed source codes
  localparam logic [1:0] SPD_SRC_SENSOR1  = 2'h1;
  localparam logic [1:0] SPD_SRC_SENSOR2  = 2'h2;
  localparam logic [1:0] SPD_SRC_RESET    = 2'h1;
  // pulses per revolution limits
  localparam int         PPR_WIDTH        = 14;
  localparam logic [13:0] PPR_MIN         = 14'h0001;
  localparam logic [13:0] PPR_MAX         = 14'h2000;
  localparam logic [13:0] PPR_RESET       = 14'h0400;
  localparam logic [15:0] MIN_FREQ_RESET  = 16'h015E; // 3.50 Hz in 0.01 Hz
  // re-initialization time after commissioning end
  localparam int         REINIT_TIME_US   = 100;
  localparam int         CLK_MHZ          = 125;
  localparam int         REINIT_CYCLES    = REINIT_TIME_US * CLK_MHZ;
  localparam int         CNT_WIDTH        = 32;
  localparam logic [1:0] SENS_MODE_OFF    = 2'h0;
endpackage : drs_pkg

//--- drs_encoder.sv
`timescale 1ns/1ps
// quadrature decoder for speed sensor 1
module drs_encoder #(
  parameter int CW = 32                      // count width
) (
  input  wire logic          i_clock,        // system clock
  input  wire logic          i_rst_n,        // synchronous-released reset
  input  wire logic          i_enable,       // sensor active
  input  wire logic          i_track_a,      // synced track a
  input  wire logic          i_track_b,      // synced track b
  input  wire logic          i_zero,         // synced zero track
  input  wire logic [13:0]   i_ppr,          // pulses per revolution
  output logic               o_dir_ccw,      // direction flag
  output logic               o_step,         // one-cycle edge pulse
  output logic [CW-1:0]      o_position,     // edge count within revolution
  output logic [CW-1:0]      o_revs          // revolution count
);
  import drs_pkg::*;
  initial begin
    if (CW < 16) $error("drs_encoder: CW too small");
  end

  logic        a_reg;
  logic        b_reg;
  logic        z_reg;
  logic        step;
  logic        ccw;
  logic [CW-1:0] edges_per_rev;

  // four edges per line in quadrature
  assign edges_per_rev = CW'({i_ppr, 2'b00});
  assign step = i_enable && ((i_track_a ^ a_reg) || (i_track_b ^ b_reg));
  // phase order: a leading b is clockwise
  assign ccw  = (i_track_a ^ a_reg) ? (i_track_a == i_track_b)
                                    : (i_track_a != i_track_b);

  // previous track levels
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      z_reg <= 1'b0;
    end else begin
      a_reg <= i_track_a;
      b_reg <= i_track_b;
      z_reg <= i_zero;
    end
  end

  // direction and step outputs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dir_ccw <= 1'b0;
      o_step    <= 1'b0;
    end else begin
      o_step <= step;
      if (step) o_dir_ccw <= ccw;
    end
  end

  // position scaled by pulses per revolution, zero track realigns
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_position <= '0;
      o_revs     <= '0;
    end else if (i_enable && i_zero && !z_reg) begin
      o_position <= '0;
    end else if (step) begin
      if (!ccw) begin
        if (o_position >= edges_per_rev - CW'(1)) begin
          o_position <= '0;
          o_revs     <= o_revs + CW'(1);
        end else begin
          o_position <= o_position + CW'(1);
        end
      end else begin
        if (o_position == '0) begin
          o_position <= edges_per_rev - CW'(1);
          o_revs     <= o_revs - CW'(1);
        end else begin
          o_position <= o_position - CW'(1);
        end
      end
    end
  end
endmodule : drs_encoder

//--- drs_top.sv
// Functional notes
// - Multi-function mode 1 is a voltage reference, 2 a current reference, 3 a digital input.
// - Release plus clockwise or anticlockwise start runs the drive to the minimum frequency.
// - Dropping release disables the output stage and engages the brake if fitted.
// - Ending commissioning resets and re-initializes with the fault relay asserted.
// - Speed source 1 (default) is sensor 1; 2 is sensor 2 only with a module present.
// - Sensor 1 track A is the fifth input, track B the fourth, zero the sixth.
// - Sensor 1 pulses per revolution accept 1 to 8192, default 1024.
// - Sensor 2 pulses per revolution accept 1 to 8192, default 1024.
// - An active sensor 1 mode withdraws inputs four to six from other functions.
// - An active sensor 2 mode withdraws the two lowest module inputs from other functions.
// - Sensor 2 settings are taken only when the module supports them.
// - After commissioning show output frequency; two confirms store another value.
`timescale 1ns/1ps
module drs_top #(
  parameter int REINIT_CNT = drs_pkg::REINIT_CYCLES, // re-init length
  parameter int MOD_INPUTS = 4                       // module digital inputs
) (
  input  wire logic                  i_clock,        // 125 MHz clock
  input  wire logic                  i_arst_n,       // async reset
  input  wire logic                  i_run_release_input,     // release pin
  input  wire logic                  i_clockwise_start_input, // cw start pin
  input  wire logic                  i_anticlockwise_start_input, // ccw pin
  input  wire logic                  i_encoder_track_a_input, // fifth input
  input  wire logic                  i_encoder_track_b_input, // fourth input
  input  wire logic                  i_encoder_zero_track_input, // sixth in
  input  wire logic                  i_mod_inputs_n_unused, // unused spare
  input  wire logic [MOD_INPUTS-1:0] i_module_inputs,  // module dig. inputs
  input  wire logic                  i_module_present, // expansion fitted
  input  wire logic                  i_module_sensor2, // module has sensor 2
  input  wire logic [1:0]            i_multi_function_input_mode, // mode
  input  wire logic                  i_multi_function_digital_path, // pin
  input  wire logic [1:0]            i_speed_source,  // speed source code
  input  wire logic [1:0]            i_sensor1_mode,  // sensor 1 mode
  input  wire logic [1:0]            i_sensor2_mode,  // sensor 2 mode
  input  wire logic [13:0]           i_sensor1_ppr,   // sensor 1 ppr
  input  wire logic [13:0]           i_sensor2_ppr,   // sensor 2 ppr
  input  wire logic                  i_sensor2_level, // sensor 2 level
  input  wire logic                  i_config_write,  // settings strobe
  input  wire logic [15:0]           i_min_frequency, // minimum freq 0.01Hz
  input  wire logic                  i_brake_fitted,  // brake installed
  input  wire logic                  i_commission_end, // end confirmed pulse
  input  wire logic                  i_confirm_key,   // confirm key pulse
  input  wire logic [7:0]            i_display_select, // selected value
  input  wire logic                  i_sensor2_step,  // module sensor step
  input  wire logic                  i_sensor2_dir_ccw, // module direction
  output logic                       o_stage_enable,  // power stage on
  output logic                       o_brake_on,      // brake engaged
  output logic                       o_run_ccw,       // running anticlockwise
  output logic [15:0]                o_freq_target,   // target frequency
  output logic                       o_fault_relay_output, // fault relay
  output logic                       o_initializing,  // re-init in progress
  output logic                       o_mfi_voltage,   // analog voltage ref
  output logic                       o_mfi_current,   // analog current ref
  output logic                       o_mfi_digital,   // digital path level
  output logic [1:0]                 o_speed_source,  // active source
  output logic [13:0]                o_sensor1_ppr,   // accepted ppr 1
  output logic [13:0]                o_sensor2_ppr,   // accepted ppr 2
  output logic                       o_sensor2_level, // accepted level
  output logic                       o_sensor2_active, // sensor 2 in use
  output logic                       o_speed_step,    // selected sensor step
  output logic                       o_speed_dir_ccw, // selected direction
  output logic                       o_pins456_free,  // inputs 4-6 usable
  output logic [MOD_INPUTS-1:0]      o_module_inputs_free, // usable inputs
  output logic [31:0]                o_enc_position,  // sensor 1 position
  output logic [7:0]                 o_display_value, // shown actual value
  output logic                       o_display_ack    // confirmation shown
);
  import drs_pkg::*;
  initial begin
    if (REINIT_CNT < 1) $error("drs_top: REINIT_CNT must be positive");
    if (MOD_INPUTS < 2) $error("drs_top: MOD_INPUTS must be at least 2");
  end

  localparam logic [7:0] DISP_OUT_FREQ = 8'hF1; // output frequency code
  localparam logic [31:0] REINIT_LAST = 32'(REINIT_CNT - 1);

  typedef enum logic [1:0] {ST_RUN, ST_REINIT} drs_state_t;
  typedef enum logic [1:0] {KY_IDLE, KY_SHOWN} drs_key_t;

  logic        rst_s1_reg;
  logic        rst_n;
  logic [5:0]  s1_reg;
  logic [5:0]  s2_reg;
  logic [MOD_INPUTS-1:0] m1_reg;
  logic [MOD_INPUTS-1:0] m2_reg;
  drs_state_t  state_reg;
  drs_key_t    key_reg;
  logic [31:0] cnt_reg;
  logic [7:0]  disp_saved_reg;
  logic        run_req;
  logic        s1_on;
  logic        s2_on;
  logic        enc_step;
  logic        enc_ccw;
  logic [31:0] enc_pos;

  // reset release synchroniser
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pin synchronisers
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      m1_reg <= '0;
      m2_reg <= '0;
    end else begin
      s1_reg <= {i_multi_function_digital_path, i_encoder_zero_track_input,
                 i_encoder_track_a_input, i_encoder_track_b_input,
                 i_anticlockwise_start_input,
                 i_run_release_input};
      s2_reg <= s1_reg;
      m1_reg <= i_module_inputs;
      m2_reg <= m1_reg;
    end
  end

  // clockwise start kept on its own synchroniser bit pair
  logic cw_s1_reg;
  logic cw_s2_reg;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cw_s1_reg <= 1'b0;
      cw_s2_reg <= 1'b0;
    end else begin
      cw_s1_reg <= i_clockwise_start_input;
      cw_s2_reg <= cw_s1_reg;
    end
  end

  assign s1_on   = (i_sensor1_mode != SENS_MODE_OFF);
  assign s2_on   = (i_sensor2_mode != SENS_MODE_OFF) && i_module_present
                   && i_module_sensor2;
  assign run_req = s2_reg[0] && (cw_s2_reg || s2_reg[1])
                   && (state_reg == ST_RUN);

  // sensor 1 decoder: a on fifth, b on fourth, z on sixth input
  drs_encoder #(
    .CW         (32)
  ) u_enc (
    .i_clock    (i_clock),
    .i_rst_n    (rst_n),
    .i_enable   (s1_on),
    .i_track_a  (s2_reg[3]),
    .i_track_b  (s2_reg[2]),
    .i_zero     (s2_reg[4]),
    .i_ppr      (o_sensor1_ppr),
    .o_dir_ccw  (enc_ccw),
    .o_step     (enc_step),
    .o_position (enc_pos),
    .o_revs     ()
  );

  // commissioning end: reset and re-initialize with fault relay on
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          cnt_reg <= '0;
          if (i_commission_end) state_reg <= ST_REINIT;
        end
        ST_REINIT: begin
          cnt_reg <= cnt_reg + 32'h00000001;
          if (cnt_reg >= REINIT_LAST) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // run enable, brake and target frequency
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_stage_enable       <= 1'b0;
      o_brake_on           <= 1'b0;
      o_run_ccw            <= 1'b0;
      o_freq_target        <= '0;
      o_fault_relay_output <= 1'b0;
      o_initializing       <= 1'b0;
    end else begin
      o_stage_enable       <= run_req;
      o_brake_on           <= !s2_reg[0] && i_brake_fitted;
      o_run_ccw            <= run_req && !cw_s2_reg;
      o_freq_target        <= run_req ? i_min_frequency : 16'h0000;
      o_fault_relay_output <= (state_reg == ST_REINIT) ||
                              (state_reg == ST_RUN && i_commission_end);
      o_initializing       <= (state_reg == ST_REINIT);
    end
  end

  // multi-function input mode decode
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_mfi_voltage <= 1'b0;
      o_mfi_current <= 1'b0;
      o_mfi_digital <= 1'b0;
    end else begin
      o_mfi_voltage <= (i_multi_function_input_mode == MFI_MODE_VOLTAGE);
      o_mfi_current <= (i_multi_function_input_mode == MFI_MODE_CURRENT);
      o_mfi_digital <= (i_multi_function_input_mode == MFI_MODE_DIGITAL)
                       && s2_reg[5];
    end
  end

  // settings: range checked, sensor 2 only with supporting module
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_speed_source  <= SPD_SRC_RESET;
      o_sensor1_ppr   <= PPR_RESET;
      o_sensor2_ppr   <= PPR_RESET;
      o_sensor2_level <= 1'b0;
    end else if (i_config_write) begin
      if (i_speed_source == SPD_SRC_SENSOR1 ||
          (i_speed_source == SPD_SRC_SENSOR2 && i_module_present))
        o_speed_source <= i_speed_source;
      if (i_sensor1_ppr >= PPR_MIN && i_sensor1_ppr <= PPR_MAX)
        o_sensor1_ppr <= i_sensor1_ppr;
      if (s2_on && i_sensor2_ppr >= PPR_MIN && i_sensor2_ppr <= PPR_MAX)
        o_sensor2_ppr <= i_sensor2_ppr;
      if (s2_on)
        o_sensor2_level <= i_sensor2_level;
    end
  end

  // speed feedback select and pin withdrawal
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_sensor2_active     <= 1'b0;
      o_speed_step         <= 1'b0;
      o_speed_dir_ccw      <= 1'b0;
      o_pins456_free       <= 1'b1;
      o_module_inputs_free <= '0;
      o_enc_position       <= '0;
    end else begin
      o_sensor2_active <= s2_on;
      if (o_speed_source == SPD_SRC_SENSOR2 && s2_on) begin
        o_speed_step    <= i_sensor2_step;
        o_speed_dir_ccw <= i_sensor2_dir_ccw;
      end else begin
        o_speed_step    <= enc_step;
        o_speed_dir_ccw <= enc_ccw;
      end
      o_pins456_free       <= !s1_on;
      o_module_inputs_free <= s2_on ?
        {{(MOD_INPUTS-2){1'b1}}, 2'b00} & m2_reg : m2_reg;
      o_enc_position       <= enc_pos;
    end
  end

  // display selection: two confirm presses store the value
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      key_reg         <= KY_IDLE;
      disp_saved_reg  <= DISP_OUT_FREQ;
      o_display_value <= DISP_OUT_FREQ;
      o_display_ack   <= 1'b0;
    end else begin
      o_display_ack <= 1'b0;
      unique case (key_reg)
        KY_IDLE: if (i_confirm_key) key_reg <= KY_SHOWN;
        KY_SHOWN: if (i_confirm_key) begin
          key_reg        <= KY_IDLE;
          disp_saved_reg <= i_display_select;
          o_display_ack  <= 1'b1;
        end
        default: key_reg <= KY_IDLE;
      endcase
      if (state_reg == ST_REINIT) o_display_value <= disp_saved_reg;
      else if (key_reg == KY_SHOWN) o_display_value <= i_display_select;
    end
  end
endmodule : drs_top

//--- drs_enc_model.sv
`timescale 1ns/1ps
// quadrature encoder with zero track, stepped one edge at a time
module drs_enc_model (
  input  wire logic i_clock,   // system clock
  input  wire logic i_arst_n,  // async reset
  input  wire logic i_step,    // advance one edge
  input  wire logic i_reverse, // walk backwards
  input  wire logic i_zero,    // raise zero track
  output logic      o_track_a, // track a, leads b forward
  output logic      o_track_b, // track b
  output logic      o_zero     // zero track
);
  logic [1:0] phase_reg;
  // gray phase walk, so only one track changes per step
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) phase_reg <= 2'h0;
    else if (i_step) phase_reg <= i_reverse ? phase_reg - 2'h1 : phase_reg + 2'h1;
  end
  // track levels from phase
  assign o_track_a = (phase_reg == 2'h1) || (phase_reg == 2'h2);
  assign o_track_b = phase_reg[1];
  assign o_zero    = i_zero;
endmodule : drs_enc_model

//--- drs_properties.sv
`timescale 1ns/1ps
module drs_properties #(
  parameter int REINIT_CNT = 8               // re-init length
) (
  input wire logic        i_clock,             // clock
  input wire logic        i_arst_n,            // async reset
  input wire logic        i_run_release_input, // release pin
  input wire logic        i_clockwise_start_input, // cw pin
  input wire logic        i_brake_fitted,      // brake installed
  input wire logic        i_commission_end,    // end pulse
  input wire logic        i_module_present,    // module fitted
  input wire logic        o_stage_enable,      // stage on
  input wire logic        o_brake_on,          // brake on
  input wire logic        o_fault_relay_output, // fault relay
  input wire logic        o_initializing,      // re-init
  input wire logic        o_mfi_voltage,       // voltage ref
  input wire logic        o_mfi_current,       // current ref
  input wire logic [1:0]  o_speed_source,      // source
  input wire logic [13:0] o_sensor1_ppr,       // ppr 1
  input wire logic [13:0] o_sensor2_ppr,       // ppr 2
  input wire logic        o_display_ack        // ack pulse
);
  import drs_pkg::*;
  logic [15:0] relay_cnt_reg;
  // length of the current fault relay pulse
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) relay_cnt_reg <= 16'h0000;
    else if (o_fault_relay_output) relay_cnt_reg <= relay_cnt_reg + 16'h0001;
    else relay_cnt_reg <= 16'h0000;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  mfi_one_ref_a: assert property (!(o_mfi_voltage && o_mfi_current))
    else $error("both analog reference kinds active");
  run_start_a: assert property ((i_run_release_input && i_clockwise_start_input
    && !o_initializing)[*8] |-> o_stage_enable)
    else $error("release and start did not enable the stage");
  stop_stage_a: assert property ((!i_run_release_input)[*4] |-> !o_stage_enable)
    else $error("stage still on after release dropped");
  brake_engage_a: assert property ((!i_run_release_input && i_brake_fitted)[*6]
    |-> o_brake_on)
    else $error("brake not engaged after release dropped");
  relay_hold_a: assert property (i_commission_end |=> o_fault_relay_output[*8])
    else $error("fault relay not held after commissioning end");
  relay_len_a: assert property ($fell(o_fault_relay_output)
    |-> relay_cnt_reg == 16'(REINIT_CNT + 1))
    else $error("fault relay pulse length wrong");
  source_refuse_a: assert property ($rose(o_speed_source == SPD_SRC_SENSOR2)
    |-> $past(i_module_present))
    else $error("sensor 2 source taken without module");
  ppr1_range_a: assert property (o_sensor1_ppr >= PPR_MIN && o_sensor1_ppr <= PPR_MAX)
    else $error("sensor 1 ppr out of range");
  ppr2_range_a: assert property (o_sensor2_ppr >= PPR_MIN && o_sensor2_ppr <= PPR_MAX)
    else $error("sensor 2 ppr out of range");
  ack_pulse_a: assert property (o_display_ack |=> !o_display_ack)
    else $error("display ack longer than one cycle");
endmodule : drs_properties
bind drs_top drs_properties #(.REINIT_CNT(REINIT_CNT)) i_drs_properties (
  .i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_run_release_input(i_run_release_input),
  .i_clockwise_start_input(i_clockwise_start_input),
  .i_brake_fitted(i_brake_fitted), .i_commission_end(i_commission_end),
  .i_module_present(i_module_present), .o_stage_enable(o_stage_enable),
  .o_brake_on(o_brake_on), .o_fault_relay_output(o_fault_relay_output),
  .o_initializing(o_initializing), .o_mfi_voltage(o_mfi_voltage),
  .o_mfi_current(o_mfi_current), .o_speed_source(o_speed_source),
  .o_sensor1_ppr(o_sensor1_ppr), .o_sensor2_ppr(o_sensor2_ppr),
  .o_display_ack(o_display_ack));

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import drs_pkg::*;
  typedef struct packed {
    logic [1:0] mode; logic [1:0] src; logic mod; logic [13:0] ppr;
    logic [2:0] e_mfi; logic [1:0] e_src; logic [13:0] e_p1; logic [13:0] e_p2;
    logic e_act;
  } drs_row_t;
  localparam drs_row_t ROWS [5] = '{
    '{MFI_MODE_VOLTAGE, SPD_SRC_SENSOR1, 1'b0, 14'h01F4, 3'h4, 2'h1, 14'h01F4, 14'h0400, 1'b0},
    '{MFI_MODE_CURRENT, SPD_SRC_SENSOR2, 1'b0, 14'h0000, 3'h2, 2'h1, 14'h01F4, 14'h0400, 1'b0},
    '{MFI_MODE_DIGITAL, SPD_SRC_SENSOR2, 1'b1, 14'h2000, 3'h1, 2'h2, 14'h2000, 14'h2000, 1'b1},
    '{MFI_MODE_VOLTAGE, SPD_SRC_SENSOR1, 1'b1, 14'h2001, 3'h4, 2'h1, 14'h2000, 14'h2000, 1'b1},
    '{MFI_MODE_CURRENT, SPD_SRC_SENSOR1, 1'b1, 14'h0001, 3'h2, 2'h1, 14'h0001, 14'h0001, 1'b1}};
  logic clock, arst_n, rel, cw, ccw, ta, tb, tz, dig, mod, lvl, wr, brk, cend, conf;
  logic step, rev, zreq;
  logic [1:0] mode, src, s1m, s2m;
  logic [13:0] ppr;
  logic [7:0] sel;
  logic stage, brake, rccw, relay, init, mv, mc, md, s2lvl, s2act, sstep, sdir, p456;
  logic dack;
  logic [15:0] ftgt;
  logic [1:0] osrc;
  logic [13:0] op1, op2;
  logic [3:0] mfree, minp;
  logic [31:0] pos;
  logic [7:0] dval;
  int mismatches, checked, n;
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  drs_top #(.REINIT_CNT(8)) i_drs_top (.i_clock(clock), .i_arst_n(arst_n),
    .i_run_release_input(rel), .i_clockwise_start_input(cw),
    .i_anticlockwise_start_input(ccw), .i_encoder_track_a_input(ta),
    .i_encoder_track_b_input(tb), .i_encoder_zero_track_input(tz),
    .i_mod_inputs_n_unused(1'b0), .i_module_inputs(minp), .i_module_present(mod),
    .i_module_sensor2(1'b1), .i_multi_function_input_mode(mode),
    .i_multi_function_digital_path(dig), .i_speed_source(src), .i_sensor1_mode(s1m),
    .i_sensor2_mode(s2m), .i_sensor1_ppr(ppr), .i_sensor2_ppr(ppr),
    .i_sensor2_level(lvl), .i_config_write(wr), .i_min_frequency(MIN_FREQ_RESET),
    .i_brake_fitted(brk), .i_commission_end(cend), .i_confirm_key(conf),
    .i_display_select(sel), .i_sensor2_step(1'b0), .i_sensor2_dir_ccw(1'b0),
    .o_stage_enable(stage), .o_brake_on(brake), .o_run_ccw(rccw),
    .o_freq_target(ftgt), .o_fault_relay_output(relay), .o_initializing(init),
    .o_mfi_voltage(mv), .o_mfi_current(mc), .o_mfi_digital(md),
    .o_speed_source(osrc), .o_sensor1_ppr(op1), .o_sensor2_ppr(op2),
    .o_sensor2_level(s2lvl), .o_sensor2_active(s2act), .o_speed_step(sstep),
    .o_speed_dir_ccw(sdir), .o_pins456_free(p456), .o_module_inputs_free(mfree),
    .o_enc_position(pos), .o_display_value(dval), .o_display_ack(dack));
  drs_enc_model i_drs_enc_model (.i_clock(clock), .i_arst_n(arst_n), .i_step(step),
    .i_reverse(rev), .i_zero(zreq), .o_track_a(ta), .o_track_b(tb), .o_zero(tz));
  task automatic cycles(input int k);
    repeat (k) @(negedge clock);
  endtask : cycles
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic cfg_pulse();
    wr = 1'b1;
    cycles(1);
    wr = 1'b0;
    cycles(5);
  endtask : cfg_pulse
  task automatic pulse(ref logic s);
    s = 1'b1;
    cycles(1);
    s = 1'b0;
  endtask : pulse
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // main sequence: reset, table rows, then hand-written cases
  initial begin
    {arst_n, rel, cw, ccw, wr, cend, conf, step, rev, zreq, mod, lvl} = '0;
    {dig, brk} = 2'h3;
    mode = MFI_MODE_VOLTAGE;
    src = SPD_SRC_SENSOR1;
    s1m = 2'h1;
    s2m = 2'h1;
    minp = 4'hF;
    ppr = PPR_RESET;
    sel = 8'hF1;
    cycles(15);
    check({osrc, op1, op2}, {SPD_SRC_RESET, PPR_RESET, PPR_RESET});
    check({dval, p456}, {8'hF1, 1'b1});
    cycles(1);
    arst_n = 1'b1;
    cycles(4);
    foreach (ROWS[k]) begin
      {mode, src, mod, ppr} = {ROWS[k].mode, ROWS[k].src, ROWS[k].mod, ROWS[k].ppr};
      lvl = ROWS[k].mod;
      cfg_pulse();
      check({mv, mc, md}, ROWS[k].e_mfi);
      check(osrc, ROWS[k].e_src);
      check({op1, op2}, {ROWS[k].e_p1, ROWS[k].e_p2});
      check({s2act, s2lvl}, {2{ROWS[k].e_act}});
      check(p456, 1'b0);
      check(mfree, ROWS[k].e_act ? 4'hC : 4'hF);
    end
    // encoder: eight forward edges, three back, then zero track
    // ppr of 1 from the last row gives four edges per revolution
    for (n = 0; n < 11; n++) begin
      rev = (n >= 8);
      pulse(step);
      cycles(4); // position output lags the decoder by one cycle
      if (n == 6) check({pos, sdir}, {32'h3, 1'b0});
    end
    check({pos, sdir}, {32'h1, 1'b1});
    zreq = 1'b1;
    cycles(5);
    check(pos, 32'h0);
    zreq = 1'b0;
    // run, direction change, release drop
    {rel, cw} = 2'h3;
    cycles(6);
    check({stage, ftgt, brake}, {1'b1, MIN_FREQ_RESET, 1'b0});
    {cw, ccw} = 2'h1;
    cycles(6);
    check({stage, rccw}, 2'h3);
    {rel, ccw} = 2'h0;
    cycles(6);
    check({stage, brake}, 2'h1);
    s1m = SENS_MODE_OFF;
    s2m = SENS_MODE_OFF;
    cfg_pulse();
    check(p456, 1'b1);
    check({s2act, mfree}, {1'b0, 4'hF});
    // two confirms store the display choice
    sel = 8'h2A;
    pulse(conf);
    cycles(2);
    pulse(conf);
    check(dack, 1'b1);
    cycles(1);
    check(dack, 1'b0);
    // commissioning end with a run request standing
    {rel, cw} = 2'h3;
    pulse(cend);
    cycles(2);
    check({relay, stage}, 2'h2);
    for (n = 0; n < 40 && relay !== 1'b0; n++) cycles(1);
    check(relay, 1'b0);
    check(n + 2, 32'h9);
    cycles(8);
    check({dval, stage}, {8'h2A, 1'b1});
    // second reset in mid-run
    arst_n = 1'b0;
    cycles(2);
    check({osrc, op1, stage}, {SPD_SRC_RESET, PPR_RESET, 1'b0});
    // release again with release and start still standing
    arst_n = 1'b1;
    cycles(2);
    check(stage, 1'b0);
    cycles(4);
    check({stage, op1}, {1'b1, PPR_RESET});
    give_verdict();
  end
endmodule : testbench
